// [verilog/lpd_pin_if.sv]
// Command and data pin interface of a four-bank low-power DDR device
`timescale 1ns/1ns
`include "lpd_consts.svh"

module lpd_pin_if (
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire logic                   cke,
  input  wire lpd_pkg::lpd_cmd_pins_t pins,
  input  wire lpd_pkg::lpd_pair_t     dq_in,
  input  wire lpd_pkg::lpd_mask_t     write_byte_mask,
  input  wire logic                   strobe_in_valid,
  input  wire lpd_pkg::lpd_pair_t     core_rd_data,
  input  wire logic                   core_rd_valid,
  output lpd_pkg::lpd_cmd_t           cmd_r,
  output logic [`LPD_ADDR_W-1:0]      mode_opcode_r,
  output logic [`LPD_BANKS-1:0]       open_rows_r,
  output lpd_pkg::lpd_pwr_t           pwr_state_r,
  output logic                        clocks_run,
  output logic                        input_buf_en,
  output lpd_pkg::lpd_pair_t          dq_out_r,
  output logic                        dq_oe_r,
  output logic [1:0]                  strobe_out_r,
  output logic                        strobe_oe_r,
  output lpd_pkg::lpd_pair_t          wr_data_r,
  output logic [2*`LPD_LANES-1:0]     wr_byte_en_r,
  output logic                        wr_valid_r
);

  // ------------------------------------------------------------
  // Command decode helper
  // ------------------------------------------------------------
  function automatic lpd_pkg::lpd_op_t lpd_decode(
    input lpd_pkg::lpd_cmd_pins_t p
  );
    lpd_pkg::lpd_op_t op;
    op = lpd_pkg::LPD_OP_NONE;
    if (!p.cs_n)
    begin
      case ({p.ras_n, p.cas_n, p.we_n})
        `LPD_CODE_ACT: op = lpd_pkg::LPD_OP_ACT;
        `LPD_CODE_RD:  op = lpd_pkg::LPD_OP_READ;
        `LPD_CODE_WR:  op = lpd_pkg::LPD_OP_WRITE;
        `LPD_CODE_PRE: op = lpd_pkg::LPD_OP_PRE;
        `LPD_CODE_REF: op = lpd_pkg::LPD_OP_REF;
        `LPD_CODE_MRL: op = lpd_pkg::LPD_OP_MRL;
        default:       op = lpd_pkg::LPD_OP_NONE;
      endcase
    end
    return op;
  endfunction

  // ------------------------------------------------------------
  // Pin sampling
  // ------------------------------------------------------------
  lpd_pkg::lpd_cmd_pins_t pins_r;
  logic                   cke_r;
  lpd_pkg::lpd_op_t       op_now;
  lpd_pkg::lpd_op_t       op_raw;
  logic                   running;

  // Buffers other than clock and enable are dark outside RUN
  assign running      = (pwr_state_r == lpd_pkg::LPD_RUN);
  assign input_buf_en = running;
  // Self-refresh exit must not wait for a sampled edge
  assign clocks_run   = running ||
                        (pwr_state_r == lpd_pkg::LPD_SELF_REF &&
                         cke);

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pins_r <= '1;
      cke_r  <= 1'b0;
    end
    else
    begin
      cke_r <= cke;
      if (input_buf_en)
        pins_r <= pins;
      else
        pins_r <= '1;
    end
  end

  assign op_raw = lpd_decode(pins_r);
  assign op_now = (running && cke_r) ? op_raw : lpd_pkg::LPD_OP_NONE;

  // ------------------------------------------------------------
  // Decoded command and mode opcode
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      cmd_r <= '0;
    else
    begin
      cmd_r.valid               <= (op_now != lpd_pkg::LPD_OP_NONE);
      cmd_r.op                  <= op_now;
      cmd_r.bank_select         <= pins_r.bank_select;
      cmd_r.addr                <= pins_r.addr;
      cmd_r.auto_precharge_flag <= pins_r.addr[`LPD_AP_BIT];
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      mode_opcode_r <= `LPD_MODE_RST;
    else if (op_now == lpd_pkg::LPD_OP_MRL)
      mode_opcode_r <= pins_r.addr;
  end

  // ------------------------------------------------------------
  // Open-row tracking per bank
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      open_rows_r <= `LPD_OPEN_RST;
    else if (op_now == lpd_pkg::LPD_OP_ACT)
      open_rows_r[pins_r.bank_select] <= 1'b1;
    else if (op_now == lpd_pkg::LPD_OP_PRE)
    begin
      if (pins_r.addr[`LPD_AP_BIT])
        open_rows_r <= '0;
      else
        open_rows_r[pins_r.bank_select] <= 1'b0;
    end
    else if ((op_now == lpd_pkg::LPD_OP_READ ||
              op_now == lpd_pkg::LPD_OP_WRITE) &&
             pins_r.addr[`LPD_AP_BIT])
      open_rows_r[pins_r.bank_select] <= 1'b0;
  end

  // ------------------------------------------------------------
  // Power state
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      pwr_state_r <= lpd_pkg::LPD_RUN;
    else
    begin
      case (pwr_state_r)
        lpd_pkg::LPD_RUN:
          if (!cke)
          begin
            // Refresh issued with enable dropping and no row open means self refresh
            if (lpd_decode(pins) == lpd_pkg::LPD_OP_REF &&
                open_rows_r == '0)
              pwr_state_r <= lpd_pkg::LPD_SELF_REF;
            else if (open_rows_r != '0)
              pwr_state_r <= lpd_pkg::LPD_OPEN_PD;
            else
              pwr_state_r <= lpd_pkg::LPD_IDLE_PD;
          end
        lpd_pkg::LPD_IDLE_PD,
        lpd_pkg::LPD_OPEN_PD:
          if (cke)
            pwr_state_r <= lpd_pkg::LPD_RUN;
        lpd_pkg::LPD_SELF_REF:
          if (clocks_run)
            pwr_state_r <= lpd_pkg::LPD_RUN;
        default:
          pwr_state_r <= lpd_pkg::LPD_RUN;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Read data and strobe drive
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      dq_out_r     <= '0;
      dq_oe_r      <= 1'b0;
      strobe_out_r <= 2'h0;
      strobe_oe_r  <= 1'b0;
    end
    else
    begin
      // Drivers are off from the first edge after the device stops running, as the enables are registered
      dq_oe_r     <= core_rd_valid && running;
      strobe_oe_r <= core_rd_valid && running;
      if (core_rd_valid && running)
      begin
        dq_out_r     <= core_rd_data;
        strobe_out_r <= `LPD_STROBE_RD;
      end
      else
        strobe_out_r <= 2'h0;
    end
  end

  // ------------------------------------------------------------
  // Write capture on both strobe edges
  // ------------------------------------------------------------
  logic wr_cap;

  assign wr_cap = strobe_in_valid && running;

  lpd_lane_mask u_lane_mask (
    .clk             (clk),
    .nrst            (nrst),
    .cap_en          (wr_cap),
    .data_in         (dq_in),
    .write_byte_mask (write_byte_mask),
    .data_r          (wr_data_r),
    .byte_en_r       (wr_byte_en_r),
    .valid_r         (wr_valid_r)
  );

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_run_cmd;
    running && cke_r;
  endsequence

  a_cs_masks_cmd:
    assert property (pins_r.cs_n |=> !cmd_r.valid)
    else $error("command decoded with chip select high");
  a_pins_sampled:
    assert property (input_buf_en ##1 input_buf_en |-> pins_r == $past(pins))
    else $error("pins not registered on the clock edge");
  a_mrl_loads_op:
    assert property (s_run_cmd ##0 op_raw == lpd_pkg::LPD_OP_MRL
                     |=> mode_opcode_r == $past(pins_r.addr))
    else $error("mode opcode not taken from address");
  a_act_opens_bank:
    assert property (s_run_cmd ##0 op_raw == lpd_pkg::LPD_OP_ACT
                     |=> open_rows_r[$past(pins_r.bank_select)])
    else $error("activate left bank closed");
  a_open_pd_entry:
    assert property (running && !cke && open_rows_r != '0
                     |=> pwr_state_r == lpd_pkg::LPD_OPEN_PD)
    else $error("open rows did not give open-row power-down");
  a_idle_pd_entry:
    assert property (running && !cke && open_rows_r == '0
                     |=> pwr_state_r != lpd_pkg::LPD_RUN &&
                         pwr_state_r != lpd_pkg::LPD_OPEN_PD)
    else $error("idle banks gave wrong power-down");
  a_buf_off_pd:
    assert property (!running ##1 !running |-> pins_r == '1 && !cmd_r.valid)
    else $error("inputs seen during power-down");
  a_sr_async_exit:
    assert property (pwr_state_r == lpd_pkg::LPD_SELF_REF && cke
                     |-> clocks_run ##1 running)
    else $error("self refresh not left on enable");
  a_rd_strobe_edge:
    assert property (core_rd_valid && running
                     |=> dq_oe_r && strobe_oe_r && strobe_out_r == 2'h1)
    else $error("read strobe not aligned with data");

endmodule

// [verilog/lpd_consts.svh]
// Constants of the low-power DDR pin interface
`ifndef LPD_CONSTS_SVH
`define LPD_CONSTS_SVH

`define LPD_DATA_W      32
`define LPD_LANES       4
`define LPD_ADDR_W      13
`define LPD_BANK_W      2
`define LPD_BANKS       4
`define LPD_AP_BIT      10
// Command codes on {ras_n, cas_n, we_n}
`define LPD_CODE_MRL    3'h0
`define LPD_CODE_REF    3'h1
`define LPD_CODE_PRE    3'h2
`define LPD_CODE_ACT    3'h3
`define LPD_CODE_WR     3'h4
`define LPD_CODE_RD     3'h5
`define LPD_CODE_BST    3'h6
`define LPD_CODE_NOP    3'h7
// Reset values and read strobe pattern
`define LPD_OPEN_RST    4'h0
`define LPD_MODE_RST    13'h0000
`define LPD_STROBE_RD   2'h1

`endif

// [verilog/lpd_pkg.sv]
// Types shared by the pin interface modules
package lpd_pkg;
`include "lpd_consts.svh"

  typedef enum logic [1:0] {
    LPD_RUN,
    LPD_IDLE_PD,
    LPD_OPEN_PD,
    LPD_SELF_REF
  } lpd_pwr_t;

  typedef enum logic [2:0] {
    LPD_OP_NONE,
    LPD_OP_ACT,
    LPD_OP_READ,
    LPD_OP_WRITE,
    LPD_OP_PRE,
    LPD_OP_REF,
    LPD_OP_MRL
  } lpd_op_t;

  typedef struct packed {
    logic                    cs_n;
    logic                    ras_n;
    logic                    cas_n;
    logic                    we_n;
    logic [`LPD_BANK_W-1:0]  bank_select;
    logic [`LPD_ADDR_W-1:0]  addr;
  } lpd_cmd_pins_t;

  typedef struct packed {
    logic                    valid;
    lpd_op_t                 op;
    logic [`LPD_BANK_W-1:0]  bank_select;
    logic [`LPD_ADDR_W-1:0]  addr;
    logic                    auto_precharge_flag;
  } lpd_cmd_t;

  typedef struct packed {
    logic [`LPD_DATA_W-1:0]  rise;
    logic [`LPD_DATA_W-1:0]  fall;
  } lpd_pair_t;

  typedef struct packed {
    logic [`LPD_LANES-1:0]   rise;
    logic [`LPD_LANES-1:0]   fall;
  } lpd_mask_t;

endpackage

// [verilog/lpd_lane_mask.sv]
// Write byte-lane masking of one captured data pair
`timescale 1ns/1ns
`include "lpd_consts.svh"

module lpd_lane_mask (
  input  wire logic               clk,
  input  wire logic               nrst,
  input  wire logic               cap_en,
  input  wire lpd_pkg::lpd_pair_t data_in,
  input  wire lpd_pkg::lpd_mask_t write_byte_mask,
  output lpd_pkg::lpd_pair_t      data_r,
  output logic [2*`LPD_LANES-1:0] byte_en_r,
  output logic                    valid_r
);

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      data_r    <= '0;
      byte_en_r <= '0;
      valid_r   <= 1'b0;
    end
    else
    begin
      valid_r <= cap_en;
      if (cap_en)
      begin
        data_r    <= data_in;
        // Mask high means lane i of that half is not stored
        byte_en_r <= ~{write_byte_mask.fall,
                       write_byte_mask.rise};
      end
      else
        byte_en_r <= '0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_mask_blocks_lane:
    assert property (cap_en && write_byte_mask.rise[0] |=> !byte_en_r[0])
    else $error("masked low lane was enabled");
  a_lane_order_ok:
    assert property (cap_en |=> byte_en_r[7:4] == ~$past(write_byte_mask.fall))
    else $error("falling half masks landed on wrong lanes");

endmodule

// [test/lpd_ctrl_model.sv]
// Controller-side model driving commands, clock enable and write data
`timescale 1ns/1ns
`include "lpd_consts.svh"

module lpd_ctrl_model (
  input  wire logic               clk,
  output lpd_pkg::lpd_cmd_pins_t  pins,
  output logic                    cke,
  output lpd_pkg::lpd_pair_t      dq_in,
  output lpd_pkg::lpd_mask_t      write_byte_mask,
  output logic                    strobe_in_valid
);
  // ----------
  // Drivers
  // ----------
  initial
  begin
    cke = 1'b1;
    pins = '1;
    dq_in = '0;
    write_byte_mask = '0;
    strobe_in_valid = 1'b0;
  end

  // Bus toggles after the command so stale values never look valid
  task send(input logic cs_n, input logic [2:0] code,
            input logic [1:0] bank, input logic [12:0] addr);
    @(posedge clk);
    #1;
    pins = {cs_n, code, bank, addr};
    @(posedge clk);
    #1;
    pins = {1'b1, `LPD_CODE_NOP, ~bank, ~addr};
  endtask

  task drop_cke(input logic [2:0] code);
    @(posedge clk);
    #1;
    cke = 1'b0;
    pins = {1'b0, code, 2'h0, 13'h0000};
    @(posedge clk);
    #1;
    pins = {1'b1, `LPD_CODE_NOP, 2'h3, 13'h1fff};
  endtask

  // Self-refresh exit is judged before the next clock edge
  task raise_cke;
    @(posedge clk);
    #1;
    cke = 1'b1;
  endtask

  task put_write(input lpd_pkg::lpd_pair_t d, input lpd_pkg::lpd_mask_t m);
    @(posedge clk);
    #1;
    dq_in = d;
    write_byte_mask = m;
    strobe_in_valid = 1'b1;
  endtask

  task end_write;
    @(posedge clk);
    #1;
    strobe_in_valid = 1'b0;
    dq_in = ~dq_in;
    write_byte_mask = ~write_byte_mask;
  endtask
endmodule

// [test/lpd_pin_if_tb_top.sv]
// Self-checking testbench of the DDR command and data pin interface
`timescale 1ns/1ns
`include "lpd_consts.svh"

module lpd_pin_if_tb_top;
  logic                    clk, nrst, cke, strobe_in_valid, core_rd_valid;
  lpd_pkg::lpd_cmd_pins_t  pins;
  lpd_pkg::lpd_pair_t      dq_in, core_rd_data, dq_out_r, wr_data_r;
  lpd_pkg::lpd_mask_t      write_byte_mask;
  lpd_pkg::lpd_cmd_t       cmd_r;
  lpd_pkg::lpd_pwr_t       pwr_state_r;
  logic [12:0]             mode_opcode_r;
  logic [3:0]              open_rows_r;
  logic [1:0]              strobe_out_r;
  logic [7:0]              wr_byte_en_r;
  logic                    clocks_run, input_buf_en, dq_oe_r, strobe_oe_r;
  logic                    wr_valid_r;
  int                      bad_count, comparisons;

  lpd_ctrl_model ctl (.clk, .pins, .cke, .dq_in, .write_byte_mask,
                      .strobe_in_valid);
  lpd_pin_if uut (.clk, .nrst, .cke, .pins, .dq_in, .write_byte_mask,
                  .strobe_in_valid, .core_rd_data, .core_rd_valid, .cmd_r,
                  .mode_opcode_r, .open_rows_r, .pwr_state_r, .clocks_run,
                  .input_buf_en, .dq_out_r, .dq_oe_r, .strobe_out_r,
                  .strobe_oe_r, .wr_data_r, .wr_byte_en_r, .wr_valid_r);

  always #4 clk = ~clk;

  // ----------
  // Helpers
  // ----------
  task check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task give_verdict;
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task step;
    @(posedge clk);
    #1;
  endtask

  task cmd(input logic [2:0] code, input logic [1:0] b,
           input logic [12:0] a, input lpd_pkg::lpd_op_t op,
           input logic [3:0] rows);
    int i;
    ctl.send(1'b0, code, b, a);
    for (i = 0; i < 4 && cmd_r.valid !== 1'b1; i++)
      step();
    check(cmd_r.valid, 1'b1);
    if (cmd_r.valid !== 1'b1)
      give_verdict();
    else
    begin
      check({cmd_r.op, cmd_r.bank_select, cmd_r.addr}, {op, b, a});
      if (op == lpd_pkg::LPD_OP_READ || op == lpd_pkg::LPD_OP_WRITE)
        check(cmd_r.auto_precharge_flag, a[10]);
      check(open_rows_r, rows);
      step();
      check(cmd_r.valid, 1'b0);
    end
  endtask

  task wait_pwr(input lpd_pkg::lpd_pwr_t s);
    int i;
    for (i = 0; i < 4 && pwr_state_r !== s; i++)
      step();
    check(pwr_state_r, s);
    if (pwr_state_r !== s)
      give_verdict();
  endtask

  task rd_pulse(input lpd_pkg::lpd_pair_t d);
    step();
    core_rd_data = d;
    core_rd_valid = 1'b1;
    step();
    core_rd_valid = 1'b0;
    core_rd_data = ~d;
  endtask

  // ----------
  // Scenarios
  // ----------
  task sc_commands;
    logic [3:0] rows;
    int b;
    rows = 4'h0;
    for (b = 0; b < 4; b++)
    begin
      rows[b] = 1'b1;
      cmd(`LPD_CODE_ACT, b[1:0], {11'h200, b[1:0]},
          lpd_pkg::LPD_OP_ACT, rows);
    end
    cmd(`LPD_CODE_RD, 2'h1, 13'h041f, lpd_pkg::LPD_OP_READ, 4'hd);
    cmd(`LPD_CODE_WR, 2'h0, 13'h0020, lpd_pkg::LPD_OP_WRITE, 4'hd);
    cmd(`LPD_CODE_MRL, 2'h0, 13'h0033, lpd_pkg::LPD_OP_MRL, 4'hd);
    check(mode_opcode_r, 13'h0033);
    cmd(`LPD_CODE_REF, 2'h0, 13'h0000, lpd_pkg::LPD_OP_REF, 4'hd);
    cmd(`LPD_CODE_PRE, 2'h2, 13'h0000, lpd_pkg::LPD_OP_PRE, 4'h9);
  endtask

  task sc_deselect;
    int i;
    ctl.send(1'b1, `LPD_CODE_ACT, 2'h1, 13'h0005);
    for (i = 0; i < 3; i++)
    begin
      check({cmd_r.valid, open_rows_r}, 5'h09);
      step();
    end
    // Codes that mean no command must not pulse valid
    ctl.send(1'b0, `LPD_CODE_BST, 2'h1, 13'h0006);
    for (i = 0; i < 3; i++)
    begin
      check({cmd_r.valid, open_rows_r}, 5'h09);
      step();
    end
  endtask

  task sc_write;
    ctl.put_write(64'h1111_2222_3333_4444, 8'h18);
    ctl.put_write(64'haaaa_bbbb_cccc_dddd, 8'hf0);
    check({wr_valid_r, wr_byte_en_r}, 9'h17e);
    check(wr_data_r, 64'h1111_2222_3333_4444);
    ctl.end_write();
    check({wr_valid_r, wr_byte_en_r}, 9'h1f0);
    check(wr_data_r, 64'haaaa_bbbb_cccc_dddd);
    step();
    check(wr_valid_r, 1'b0);
  endtask

  task sc_read;
    rd_pulse(64'h0123_4567_89ab_cdef);
    check({dq_oe_r, strobe_oe_r, strobe_out_r}, 4'hd);
    check(dq_out_r, 64'h0123_4567_89ab_cdef);
    step();
    check({dq_oe_r, strobe_oe_r}, 2'h0);
  endtask

  // Open rows remain from the command scenario
  task sc_power;
    ctl.drop_cke(`LPD_CODE_NOP);
    wait_pwr(lpd_pkg::LPD_OPEN_PD);
    check({input_buf_en, clocks_run}, 2'h0);
    ctl.send(1'b0, `LPD_CODE_ACT, 2'h1, 13'h0007);
    rd_pulse(64'h5555_5555_5555_5555);
    check({dq_oe_r, open_rows_r}, 5'h09);
    ctl.put_write(64'h7777_7777_7777_7777, 8'h00);
    ctl.end_write();
    check(wr_valid_r, 1'b0);
    ctl.raise_cke();
    wait_pwr(lpd_pkg::LPD_RUN);
    check(input_buf_en, 1'b1);
    cmd(`LPD_CODE_PRE, 2'h0, 13'h0400, lpd_pkg::LPD_OP_PRE, 4'h0);
    ctl.drop_cke(`LPD_CODE_NOP);
    wait_pwr(lpd_pkg::LPD_IDLE_PD);
    ctl.raise_cke();
    wait_pwr(lpd_pkg::LPD_RUN);
    ctl.drop_cke(`LPD_CODE_REF);
    wait_pwr(lpd_pkg::LPD_SELF_REF);
    check(clocks_run, 1'b0);
    ctl.raise_cke();
    #1;
    check(clocks_run, 1'b1);
    wait_pwr(lpd_pkg::LPD_RUN);
  endtask

  // Reset in mid-run clears open rows without a clock edge
  task sc_reset;
    cmd(`LPD_CODE_ACT, 2'h3, 13'h0009, lpd_pkg::LPD_OP_ACT, 4'h8);
    cmd(`LPD_CODE_ACT, 2'h0, 13'h0001, lpd_pkg::LPD_OP_ACT, 4'h9);
    cmd(`LPD_CODE_WR, 2'h0, 13'h0400, lpd_pkg::LPD_OP_WRITE, 4'h8);
    nrst = 1'b0;
    #1;
    check({pwr_state_r, open_rows_r}, 6'h00);
    step();
    nrst = 1'b1;
    check({pwr_state_r, open_rows_r, input_buf_en, clocks_run}, 8'h03);
    cmd(`LPD_CODE_ACT, 2'h1, 13'h0011, lpd_pkg::LPD_OP_ACT, 4'h2);
  endtask

  initial
  begin
    clk = 1'b0;
    nrst = 1'b0;
    core_rd_valid = 1'b0;
    core_rd_data = '0;
    repeat (12) @(posedge clk);
    #1;
    nrst = 1'b1;
    check({pwr_state_r, open_rows_r, input_buf_en, clocks_run}, 8'h03);
    sc_commands();
    sc_deselect();
    sc_write();
    sc_read();
    sc_power();
    sc_reset();
    give_verdict();
  end
endmodule
